// [rtl/bbc_pkg.sv]
package bbc_pkg;
	typedef enum logic [3:0] {
		OP_BRANCH_IF_BIT_SET,
		OP_BRANCH_IF_BIT_CLEAR,
		OP_BRANCH_AND_CLEAR_BIT,
		OP_DECREMENT_BRANCH_NONZERO,
		OP_REGISTER_BANK_SELECT,
		OP_NO_OPERATION,
		OP_INTERRUPT_ENABLE_INSTRUCTION,
		OP_INTERRUPT_DISABLE_INSTRUCTION,
		OP_HALT,
		OP_STOP
	} bbc_op_e;
	typedef enum logic [2:0] {
		MD_SHORT_DIRECT,
		MD_SPECIAL_REG,
		MD_ACCUM,
		MD_STATUS_WORD,
		MD_POINTER_PAIR,
		MD_REG_B,
		MD_REG_C
	} bbc_mode_e;
	// status word field positions
	localparam int FLAG_IE_POS = 7;
	localparam int BANK_HI_POS = 5;
	localparam int BANK_LO_POS = 3;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	// data memory map
	localparam logic [15:0] SADDR_BASE = 16'hFE00;
	localparam logic [15:0] SFR_BASE = 16'hFF00;
	localparam logic [15:0] HSRAM_FIRST = 16'hFB00;
	localparam logic [15:0] HSRAM_LAST = 16'hFEFF;
	// register port offsets
	localparam logic [3:0] REG_ACC = 4'h0;
	localparam logic [3:0] REG_B = 4'h1;
	localparam logic [3:0] REG_C = 4'h2;
	localparam logic [3:0] REG_PTR_HI = 4'h3;
	localparam logic [3:0] REG_PTR_LO = 4'h4;
	localparam logic [3:0] REG_STATUS = 4'h5;
	localparam logic [3:0] REG_CLK_CTRL = 4'h6;
	localparam logic [3:0] REG_CORE_STATE = 4'h7;
	localparam logic [3:0] REG_PC_LO = 4'h8;
	localparam logic [3:0] REG_PC_HI = 4'h9;
	// processor clock control: divide by 2**sel, sel limited
	localparam logic [2:0] CLK_SEL_MAX = 3'h4;
	localparam logic [2:0] CLK_CTRL_RESET = 3'h0;
	// instruction lengths in bytes
	localparam logic [2:0] LEN_1 = 3'h1;
	localparam logic [2:0] LEN_2 = 3'h2;
	localparam logic [2:0] LEN_3 = 3'h3;
	localparam logic [2:0] LEN_4 = 3'h4;
	// instruction clock counts
	localparam logic [3:0] CYC_2 = 4'h2;
	localparam logic [3:0] CYC_4 = 4'h4;
	localparam logic [3:0] CYC_6 = 4'h6;
	localparam logic [3:0] CYC_8 = 4'h8;
	localparam logic [3:0] CYC_9 = 4'h9;
	localparam logic [3:0] CYC_10 = 4'hA;
	localparam logic [3:0] CYC_11 = 4'hB;
	localparam logic [3:0] CYC_12 = 4'hC;
endpackage

// [rtl/bbc_clk_div.sv]
`timescale 1ns/1ps
// cpu clock enable from the processor clock control selection
module bbc_clk_div (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// control
	input wire logic [2:0] div_sel,
	input wire logic run,
	// one-cycle enable
	output logic cpu_tick
);
	import bbc_pkg::*;
	logic [3:0] div_cnt_reg;
	logic [3:0] div_limit;

	// terminal count for divide by 2**sel
	always_comb begin
		if (div_sel > CLK_SEL_MAX) begin
			div_limit = (4'h1 << CLK_SEL_MAX) - 4'h1;
		end else begin
			div_limit = (4'h1 << div_sel) - 4'h1;
		end
	end

	// free counter, cleared while stopped
	always_ff @(posedge mclk) begin
		if (!rst_n || !run || div_cnt_reg >= div_limit) begin
			div_cnt_reg <= 4'h0;
		end else begin
			div_cnt_reg <= div_cnt_reg + 4'h1;
		end
	end

	assign cpu_tick = run && (div_cnt_reg >= div_limit);
endmodule // bbc_clk_div

// [rtl/bbc_bit_unit.sv]
`timescale 1ns/1ps
// bit test, bit clear and decrement on one operand byte
module bbc_bit_unit (
	// operand
	input wire logic [7:0] opnd,
	input wire logic [2:0] bit_sel,
	// results
	output logic bit_val,
	output logic [7:0] cleared,
	output logic [7:0] decremented,
	output logic dec_nonzero
);
	// selected bit and its cleared form
	assign bit_val = opnd[bit_sel];
	assign cleared = opnd & ~(8'h01 << bit_sel);
	// decrement first, then test
	assign decremented = opnd - 8'h01;
	assign dec_nonzero = (decremented != 8'h00);
endmodule // bbc_bit_unit

// [rtl/bbc_exec.sv]
`timescale 1ns/1ps
// execution of bit branches, decrement loops and cpu control instructions
module bbc_exec (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// decoded instruction issue
	input wire logic instr_valid,
	output logic instr_ready,
	input wire bbc_pkg::bbc_op_e instr_op,
	input wire bbc_pkg::bbc_mode_e instr_mode,
	input wire logic [2:0] instr_bit,
	input wire logic [7:0] instr_offset,
	input wire logic [7:0] instr_disp,
	input wire logic [1:0] instr_bank,
	// completion
	output logic instr_done,
	output logic branch_taken,
	output logic [15:0] pc_out,
	output logic [2:0] instr_length,
	output logic [3:0] instr_clocks,
	// data memory and special registers
	output logic [15:0] mem_addr,
	output logic mem_rd,
	output logic mem_wr,
	output logic [7:0] mem_wdata,
	input wire logic [7:0] mem_rdata,
	// cpu state
	output logic master_interrupt_flag,
	output logic [1:0] bank_select_bits,
	output logic halt_mode,
	output logic stop_mode,
	input wire logic wake,
	// register port
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata
);
	import bbc_pkg::*;

	typedef enum logic [1:0] {S_IDLE, S_READ, S_EXEC, S_WAIT} bbc_state_e;

	// area test for the fast or slow clock count
	function automatic logic is_fast(input logic [15:0] addr);
		return (addr >= HSRAM_FIRST) && (addr <= HSRAM_LAST);
	endfunction

	// operand address for memory modes
	function automatic logic [15:0] ea_for(input bbc_mode_e md, input logic [7:0] off,
		input logic [15:0] ptr);
		case (md)
			MD_SHORT_DIRECT: return SADDR_BASE + {8'h00, off};
			MD_SPECIAL_REG: return SFR_BASE + {8'h00, off};
			MD_POINTER_PAIR: return ptr;
			default: return 16'h0000;
		endcase
	endfunction

	// instruction length in bytes
	function automatic logic [2:0] len_for(input bbc_op_e op, input bbc_mode_e md);
		case (op)
			OP_BRANCH_IF_BIT_SET: return (md == MD_SPECIAL_REG) ? LEN_4 : LEN_3;
			OP_BRANCH_IF_BIT_CLEAR, OP_BRANCH_AND_CLEAR_BIT: begin
				if (md == MD_SHORT_DIRECT || md == MD_SPECIAL_REG || md == MD_STATUS_WORD) begin
					return LEN_4;
				end
				return LEN_3;
			end
			OP_DECREMENT_BRANCH_NONZERO: return (md == MD_SHORT_DIRECT) ? LEN_3 : LEN_2;
			OP_NO_OPERATION: return LEN_1;
			default: return LEN_2;
		endcase
	endfunction

	// instruction clocks, fast or slow data area
	function automatic logic [3:0] cyc_for(input bbc_op_e op, input bbc_mode_e md, input logic fast);
		case (op)
			OP_BRANCH_IF_BIT_SET: begin
				case (md)
					MD_SHORT_DIRECT: return fast ? CYC_8 : CYC_9;
					MD_SPECIAL_REG: return CYC_11;
					MD_STATUS_WORD: return CYC_9;
					MD_POINTER_PAIR: return fast ? CYC_10 : CYC_11;
					default: return CYC_8;
				endcase
			end
			OP_BRANCH_IF_BIT_CLEAR: begin
				case (md)
					MD_SHORT_DIRECT: return fast ? CYC_10 : CYC_11;
					MD_SPECIAL_REG: return CYC_11;
					MD_STATUS_WORD: return CYC_11;
					MD_POINTER_PAIR: return fast ? CYC_10 : CYC_11;
					default: return CYC_8;
				endcase
			end
			OP_BRANCH_AND_CLEAR_BIT: begin
				case (md)
					MD_SHORT_DIRECT: return fast ? CYC_10 : CYC_12;
					MD_SPECIAL_REG: return CYC_12;
					MD_STATUS_WORD: return CYC_12;
					MD_POINTER_PAIR: return fast ? CYC_10 : CYC_12;
					default: return CYC_8;
				endcase
			end
			OP_DECREMENT_BRANCH_NONZERO: begin
				if (md == MD_SHORT_DIRECT) begin
					return fast ? CYC_8 : CYC_10;
				end
				return CYC_6;
			end
			OP_REGISTER_BANK_SELECT: return CYC_4;
			OP_NO_OPERATION: return CYC_2;
			default: return CYC_6;
		endcase
	endfunction

	bbc_state_e state_reg;
	bbc_op_e op_reg;
	bbc_mode_e mode_reg;
	logic [2:0] bit_reg;
	logic [7:0] disp_reg;
	logic [1:0] bank_reg;
	logic [15:0] ea_reg;
	logic [3:0] cnt_reg;
	logic [7:0] acc_reg;
	logic [7:0] b_reg;
	logic [7:0] c_reg;
	logic [7:0] ptr_hi_reg;
	logic [7:0] ptr_lo_reg;
	logic [7:0] status_reg;
	logic [15:0] pc_reg;
	logic [2:0] clk_ctrl_reg;
	logic halt_reg;
	logic stop_reg;
	logic taken_reg;
	logic [2:0] len_reg;
	logic [3:0] clocks_reg;
	logic mem_wr_reg;
	logic [7:0] mem_wdata_reg;
	logic [7:0] reg_rdata_reg;
	logic cpu_tick;
	logic accept;
	logic mem_mode;
	logic [15:0] ea_next;
	logic [7:0] opnd;
	logic bit_val;
	logic [7:0] cleared;
	logic [7:0] decremented;
	logic dec_nonzero;
	logic taken;
	logic do_clear;
	logic do_dec;
	logic [7:0] wb_value;

	// cpu clock enable, frozen in stop mode once the stop instruction has used its clocks
	bbc_clk_div u_div (
		.mclk(mclk),
		.rst_n(rst_n),
		.div_sel(clk_ctrl_reg),
		.run(!stop_reg || state_reg != S_IDLE),
		.cpu_tick(cpu_tick)
	);

	// issue handshake and operand address
	assign instr_ready = (state_reg == S_IDLE) && !halt_reg && !stop_reg;
	assign accept = instr_valid && instr_ready;
	assign mem_mode = (instr_mode == MD_SHORT_DIRECT) || (instr_mode == MD_SPECIAL_REG)
		|| (instr_mode == MD_POINTER_PAIR);
	assign ea_next = ea_for(instr_mode, instr_offset, {ptr_hi_reg, ptr_lo_reg});

	// operand source selection
	always_comb begin
		case (mode_reg)
			MD_ACCUM: opnd = acc_reg;
			MD_STATUS_WORD: opnd = status_reg;
			MD_REG_B: opnd = b_reg;
			MD_REG_C: opnd = c_reg;
			default: opnd = mem_rdata;
		endcase
	end

	bbc_bit_unit u_bit (
		.opnd(opnd),
		.bit_sel(bit_reg),
		.bit_val(bit_val),
		.cleared(cleared),
		.decremented(decremented),
		.dec_nonzero(dec_nonzero)
	);

	// branch condition and write-back decision
	always_comb begin
		taken = 1'b0;
		do_clear = 1'b0;
		do_dec = 1'b0;
		case (op_reg)
			OP_BRANCH_IF_BIT_SET: taken = bit_val;
			OP_BRANCH_IF_BIT_CLEAR: taken = !bit_val;
			OP_BRANCH_AND_CLEAR_BIT: begin
				taken = bit_val;
				do_clear = bit_val;
			end
			OP_DECREMENT_BRANCH_NONZERO: begin
				taken = dec_nonzero;
				do_dec = 1'b1;
			end
			default: taken = 1'b0;
		endcase
		wb_value = do_dec ? decremented : cleared;
	end

	// sequencer
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state_reg <= S_IDLE;
		end else begin
			case (state_reg)
				S_IDLE: begin
					if (accept) begin
						state_reg <= mem_mode ? S_READ : S_EXEC;
					end
				end
				S_READ: state_reg <= S_EXEC;
				S_EXEC: state_reg <= S_WAIT;
				S_WAIT: begin
					if (instr_done) begin
						state_reg <= S_IDLE;
					end
				end
				default: state_reg <= S_IDLE;
			endcase
		end
	end

	// instruction latch and clock budget in cpu clocks
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			op_reg <= OP_NO_OPERATION;
			mode_reg <= MD_ACCUM;
			bit_reg <= 3'h0;
			disp_reg <= 8'h00;
			bank_reg <= 2'h0;
			ea_reg <= 16'h0000;
			cnt_reg <= 4'h0;
		end else if (accept) begin
			op_reg <= instr_op;
			mode_reg <= instr_mode;
			bit_reg <= instr_bit;
			disp_reg <= instr_disp;
			bank_reg <= instr_bank;
			ea_reg <= ea_next;
			cnt_reg <= cyc_for(instr_op, instr_mode, !mem_mode || is_fast(ea_next));
		end else if (state_reg != S_IDLE && cpu_tick && cnt_reg != 4'h0) begin
			cnt_reg <= cnt_reg - 4'h1;
		end
	end

	// program counter and completion record
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			pc_reg <= 16'h0000;
			taken_reg <= 1'b0;
			len_reg <= LEN_1;
			clocks_reg <= CYC_2;
		end else if (state_reg == S_EXEC) begin
			taken_reg <= taken;
			len_reg <= len_for(op_reg, mode_reg);
			clocks_reg <= cyc_for(op_reg, mode_reg, (mode_reg != MD_SHORT_DIRECT && mode_reg != MD_POINTER_PAIR)
				|| is_fast(ea_reg));
			if (taken) begin
				pc_reg <= pc_reg + {13'h0000, len_for(op_reg, mode_reg)} + {{8{disp_reg[7]}}, disp_reg};
			end else begin
				pc_reg <= pc_reg + {13'h0000, len_for(op_reg, mode_reg)};
			end
		end else if (reg_wr && reg_addr == REG_PC_LO) begin
			pc_reg <= {pc_reg[15:8], reg_wdata};
		end else if (reg_wr && reg_addr == REG_PC_HI) begin
			pc_reg <= {reg_wdata, pc_reg[7:0]};
		end
	end

	// working registers, instruction write-back over software
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			acc_reg <= 8'h00;
			b_reg <= 8'h00;
			c_reg <= 8'h00;
			ptr_hi_reg <= 8'h00;
			ptr_lo_reg <= 8'h00;
		end else begin
			if (reg_wr && reg_addr == REG_ACC) acc_reg <= reg_wdata;
			if (reg_wr && reg_addr == REG_B) b_reg <= reg_wdata;
			if (reg_wr && reg_addr == REG_C) c_reg <= reg_wdata;
			if (reg_wr && reg_addr == REG_PTR_HI) ptr_hi_reg <= reg_wdata;
			if (reg_wr && reg_addr == REG_PTR_LO) ptr_lo_reg <= reg_wdata;
			if (state_reg == S_EXEC && (do_clear || do_dec)) begin
				if (mode_reg == MD_ACCUM) acc_reg <= wb_value;
				if (mode_reg == MD_REG_B) b_reg <= wb_value;
				if (mode_reg == MD_REG_C) c_reg <= wb_value;
			end
		end
	end

	// status word: branch-and-clear on it, the interrupt enable/disable and bank select instructions touch its bits
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			status_reg <= STATUS_RESET;
		end else if (state_reg == S_EXEC) begin
			case (op_reg)
				OP_BRANCH_AND_CLEAR_BIT: begin
					if (do_clear && mode_reg == MD_STATUS_WORD) begin
						status_reg <= cleared;
					end
				end
				OP_INTERRUPT_ENABLE_INSTRUCTION: status_reg[FLAG_IE_POS] <= 1'b1;
				OP_INTERRUPT_DISABLE_INSTRUCTION: status_reg[FLAG_IE_POS] <= 1'b0;
				OP_REGISTER_BANK_SELECT: begin
					status_reg[BANK_HI_POS] <= bank_reg[1];
					status_reg[BANK_LO_POS] <= bank_reg[0];
				end
				default: status_reg <= status_reg;
			endcase
		end else if (reg_wr && reg_addr == REG_STATUS) begin
			status_reg <= reg_wdata;
		end
	end

	// standby modes, left on wake
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			halt_reg <= 1'b0;
			stop_reg <= 1'b0;
		end else if (state_reg == S_EXEC && op_reg == OP_HALT) begin
			halt_reg <= 1'b1;
		end else if (state_reg == S_EXEC && op_reg == OP_STOP) begin
			stop_reg <= 1'b1;
		end else if (wake) begin
			halt_reg <= 1'b0;
			stop_reg <= 1'b0;
		end
	end

	// memory write-back of cleared or decremented byte
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			mem_wr_reg <= 1'b0;
			mem_wdata_reg <= 8'h00;
		end else begin
			mem_wr_reg <= (state_reg == S_EXEC) && (do_clear || do_dec)
				&& (mode_reg == MD_SHORT_DIRECT || mode_reg == MD_SPECIAL_REG
				|| mode_reg == MD_POINTER_PAIR);
			mem_wdata_reg <= wb_value;
		end
	end

	// software clock selection
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			clk_ctrl_reg <= CLK_CTRL_RESET;
		end else if (reg_wr && reg_addr == REG_CLK_CTRL) begin
			clk_ctrl_reg <= reg_wdata[2:0];
		end
	end

	// register readback, one cycle after the strobe
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			reg_rdata_reg <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				REG_ACC: reg_rdata_reg <= acc_reg;
				REG_B: reg_rdata_reg <= b_reg;
				REG_C: reg_rdata_reg <= c_reg;
				REG_PTR_HI: reg_rdata_reg <= ptr_hi_reg;
				REG_PTR_LO: reg_rdata_reg <= ptr_lo_reg;
				REG_STATUS: reg_rdata_reg <= status_reg;
				REG_CLK_CTRL: reg_rdata_reg <= {5'h00, clk_ctrl_reg};
				REG_CORE_STATE: reg_rdata_reg <= {5'h00, state_reg != S_IDLE, stop_reg, halt_reg};
				REG_PC_LO: reg_rdata_reg <= pc_reg[7:0];
				REG_PC_HI: reg_rdata_reg <= pc_reg[15:8];
				default: reg_rdata_reg <= 8'h00;
			endcase
		end else begin
			reg_rdata_reg <= 8'h00;
		end
	end

	// outputs
	assign instr_done = (state_reg == S_WAIT) && (cnt_reg == 4'h0) && !mem_wr_reg;
	assign branch_taken = taken_reg;
	assign pc_out = pc_reg;
	assign instr_length = len_reg;
	assign instr_clocks = clocks_reg;
	assign mem_addr = ea_reg;
	assign mem_rd = (state_reg == S_READ);
	assign mem_wr = mem_wr_reg;
	assign mem_wdata = mem_wdata_reg;
	assign master_interrupt_flag = status_reg[FLAG_IE_POS];
	assign bank_select_bits = {status_reg[BANK_HI_POS], status_reg[BANK_LO_POS]};
	assign halt_mode = halt_reg;
	assign stop_mode = stop_reg;
	assign reg_rdata = reg_rdata_reg;
endmodule // bbc_exec

// [sim/bbc_mem_model.sv]
`timescale 1ns/1ps
// data memory and special registers facing the execution unit
module bbc_mem_model (
	// clock
	input wire logic mclk,
	// access from the core
	input wire logic [15:0] mem_addr,
	input wire logic mem_rd,
	input wire logic mem_wr,
	input wire logic [7:0] mem_wdata,
	output logic [7:0] mem_rdata
);
	logic [7:0] mem [0:65535];
	logic [7:0] data_reg;
	logic rd_reg;
	// one-cycle read answer, byte write-back
	always @(posedge mclk) begin
		rd_reg <= mem_rd;
		if (mem_rd) data_reg <= mem[mem_addr];
		if (mem_wr) mem[mem_addr] <= mem_wdata;
	end
	// stale data shown inverted outside the answer cycle
	assign mem_rdata = rd_reg ? data_reg : ~data_reg;
endmodule // bbc_mem_model

// [sim/bbc_exec_chk.sv]
`timescale 1ns/1ps
// result and timing checks on the execution unit ports
module bbc_exec_chk (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// issue
	input wire logic instr_valid,
	input wire logic instr_ready,
	input wire bbc_pkg::bbc_op_e instr_op,
	input wire bbc_pkg::bbc_mode_e instr_mode,
	input wire logic [7:0] instr_disp,
	input wire logic [1:0] instr_bank,
	// completion and state
	input wire logic instr_done,
	input wire logic branch_taken,
	input wire logic [15:0] pc_out,
	input wire logic [2:0] instr_length,
	input wire logic [3:0] instr_clocks,
	input wire logic mem_wr,
	input wire logic master_interrupt_flag,
	input wire logic [1:0] bank_select_bits,
	input wire logic halt_mode
);
	import bbc_pkg::*;
	bbc_op_e op_reg;
	bbc_mode_e mode_reg;
	logic [15:0] disp_reg;
	logic [15:0] pc_reg;
	logic [1:0] bank_reg;
	logic acc;
	logic bit_op;
	assign acc = instr_valid && instr_ready;
	assign bit_op = op_reg inside {OP_BRANCH_IF_BIT_SET, OP_BRANCH_IF_BIT_CLEAR, OP_BRANCH_AND_CLEAR_BIT};
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// capture of the accepted instruction
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			op_reg <= OP_NO_OPERATION;
			mode_reg <= MD_ACCUM;
			disp_reg <= 16'h0000;
			pc_reg <= 16'h0000;
			bank_reg <= 2'h0;
		end else if (acc) begin
			op_reg <= instr_op;
			mode_reg <= instr_mode;
			disp_reg <= {{8{instr_disp[7]}}, instr_disp};
			pc_reg <= pc_out;
			bank_reg <= instr_bank;
		end
	end
	a_busy_after_accept: assert property (acc |=> !instr_ready) else $error("ready after accept");
	a_done_bounded: assert property (acc |-> ##[2:250] instr_done) else $error("no completion");
	a_branch_target: assert property (instr_done && !(op_reg inside {OP_HALT, OP_STOP}) |->
		pc_out == pc_reg + {13'h0000, instr_length} + (branch_taken ? disp_reg : 16'h0000)) else $error("bad pc");
	a_accum_counts: assert property (instr_done && bit_op && mode_reg == MD_ACCUM |->
		instr_length == LEN_3 && instr_clocks == CYC_8) else $error("accum counts");
	a_sfr_counts: assert property (instr_done && bit_op && mode_reg == MD_SPECIAL_REG |-> instr_length == LEN_4 &&
		instr_clocks == (op_reg == OP_BRANCH_AND_CLEAR_BIT ? CYC_12 : CYC_11)) else $error("sfr counts");
	a_dec_counts: assert property (instr_done && op_reg == OP_DECREMENT_BRANCH_NONZERO && mode_reg != MD_SHORT_DIRECT
		|-> instr_length == LEN_2 && instr_clocks == CYC_6) else $error("dec counts");
	a_no_write_test: assert property (acc && !(instr_op inside {OP_BRANCH_AND_CLEAR_BIT, OP_DECREMENT_BRANCH_NONZERO})
		|=> !mem_wr [*8]) else $error("stray write");
	a_ie_set: assert property (instr_done && op_reg == OP_INTERRUPT_ENABLE_INSTRUCTION |-> master_interrupt_flag)
		else $error("flag not set");
	a_ie_clear: assert property (instr_done && op_reg == OP_INTERRUPT_DISABLE_INSTRUCTION |-> !master_interrupt_flag)
		else $error("flag not cleared");
	a_bank_write: assert property (instr_done && op_reg == OP_REGISTER_BANK_SELECT |->
		bank_select_bits == bank_reg && instr_clocks == CYC_4) else $error("bank bits");
	a_halt_entry: assert property (instr_done && op_reg == OP_HALT |-> halt_mode ##1 !instr_ready)
		else $error("no standby");
	a_nop_counts: assert property (instr_done && op_reg == OP_NO_OPERATION |->
		instr_length == LEN_1 && instr_clocks == CYC_2) else $error("nop counts");
endmodule // bbc_exec_chk
bind bbc_exec bbc_exec_chk chk_u (.mclk, .rst_n, .instr_valid, .instr_ready, .instr_op, .instr_mode, .instr_disp,
	.instr_bank, .instr_done, .branch_taken, .pc_out, .instr_length, .instr_clocks, .mem_wr, .master_interrupt_flag,
	.bank_select_bits, .halt_mode);

// [sim/bbc_exec_tb.sv]
`timescale 1ns/1ps
module bbc_exec_tb;
	import bbc_pkg::*;
	logic mclk, rst_n, instr_valid, instr_ready, instr_done, branch_taken, mem_rd, mem_wr, wake, reg_wr, reg_rd;
	logic master_interrupt_flag, halt_mode, stop_mode;
	bbc_op_e instr_op;
	bbc_mode_e instr_mode;
	logic [2:0] instr_bit, instr_length;
	logic [7:0] instr_offset, instr_disp, mem_wdata, mem_rdata, reg_wdata, reg_rdata;
	logic [1:0] instr_bank, bank_select_bits;
	logic [15:0] pc_out, mem_addr, pc_m;
	logic [3:0] instr_clocks, reg_addr;
	logic slow;
	int fails, num_checks, cyc;
	bbc_exec dut_u (.mclk, .rst_n, .instr_valid, .instr_ready, .instr_op, .instr_mode, .instr_bit, .instr_offset,
		.instr_disp, .instr_bank, .instr_done, .branch_taken, .pc_out, .instr_length, .instr_clocks, .mem_addr,
		.mem_rd, .mem_wr, .mem_wdata, .mem_rdata, .master_interrupt_flag, .bank_select_bits, .halt_mode,
		.stop_mode, .wake, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
	bbc_mem_model mem_u (.mclk, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata);
	// 40 MHz clock
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic give_verdict();
		if (fails == 0 && num_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task automatic reg_read(input logic [3:0] a, input logic [7:0] exp);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(negedge mclk);
		check({8'h00, reg_rdata}, {8'h00, exp});
	endtask
	// issue one instruction, wait for completion, compare results and own pc model
	task automatic run(input bbc_op_e op, input bbc_mode_e md, input logic [2:0] b, input logic [7:0] off,
		input logic [7:0] disp, input logic tk, input logic [2:0] len, input logic [3:0] clk);
		cyc = 0;
		while (!instr_ready && cyc < 300) begin
			@(negedge mclk);
			cyc++;
		end
		@(posedge mclk);
		instr_valid <= 1'b1;
		instr_op <= op;
		instr_mode <= md;
		instr_bit <= b;
		instr_offset <= off;
		instr_disp <= disp;
		instr_bank <= off[1:0];
		@(posedge mclk);
		instr_valid <= 1'b0;
		cyc = 0;
		do begin
			@(negedge mclk);
			cyc++;
		end while (instr_done !== 1'b1 && cyc < 300);
		check({15'h0000, branch_taken}, {15'h0000, tk});
		check({13'h0000, instr_length}, {13'h0000, len});
		check({12'h000, instr_clocks}, {12'h000, clk});
		pc_m = pc_m + {13'h0000, len} + (tk ? {{8{disp[7]}}, disp} : 16'h0000);
		check(pc_out, pc_m);
		// clocks count from the cycle after accept, done shows one cycle after the last
		if (!slow) check(16'(cyc), {12'h000, clk} + 16'h0001);
	endtask
	// wake pulse out of standby
	task automatic wake_up();
		@(posedge mclk);
		wake <= 1'b1;
		@(posedge mclk);
		wake <= 1'b0;
		@(negedge mclk);
		check({14'h0000, halt_mode, stop_mode}, 16'h0000);
	endtask
	// watchdog
	initial begin
		repeat (20000) @(posedge mclk);
		fails++;
		give_verdict();
	end
	initial begin
		{rst_n, instr_valid, reg_wr, reg_rd, wake, slow} = 6'h00;
		{instr_bit, instr_offset, instr_disp, instr_bank, reg_addr, reg_wdata} = '0;
		instr_op = OP_NO_OPERATION;
		instr_mode = MD_ACCUM;
		{fails, num_checks, pc_m} = '0;
		mem_u.mem[16'hFE10] = 8'h80;
		mem_u.mem[16'hFF05] = 8'h00;
		mem_u.mem[16'hFE20] = 8'h01;
		mem_u.mem[16'hFF06] = 8'h08;
		mem_u.mem[16'h1234] = 8'h02;
		mem_u.mem[16'hFE30] = 8'h01;
		repeat (8) @(posedge mclk);
		rst_n <= 1'b1;
		reg_read(REG_STATUS, 8'h00);
		reg_read(REG_CLK_CTRL, 8'h00);
		reg_read(4'hA, 8'h00);
		reg_write(REG_ACC, 8'h04);
		run(OP_BRANCH_IF_BIT_SET, MD_ACCUM, 3'h2, 8'h00, 8'h10, 1'b1, LEN_3, CYC_8);
		run(OP_BRANCH_IF_BIT_CLEAR, MD_ACCUM, 3'h2, 8'h00, 8'h10, 1'b0, LEN_3, CYC_8);
		run(OP_BRANCH_AND_CLEAR_BIT, MD_ACCUM, 3'h2, 8'h00, 8'hF0, 1'b1, LEN_3, CYC_8);
		reg_read(REG_ACC, 8'h00);
		run(OP_BRANCH_IF_BIT_SET, MD_SHORT_DIRECT, 3'h7, 8'h10, 8'hFE, 1'b1, LEN_3, CYC_8);
		run(OP_BRANCH_IF_BIT_CLEAR, MD_SHORT_DIRECT, 3'h1, 8'h10, 8'h04, 1'b1, LEN_4, CYC_10);
		run(OP_BRANCH_IF_BIT_CLEAR, MD_SPECIAL_REG, 3'h0, 8'h05, 8'h20, 1'b1, LEN_4, CYC_11);
		run(OP_BRANCH_IF_BIT_SET, MD_SPECIAL_REG, 3'h0, 8'h05, 8'h20, 1'b0, LEN_4, CYC_11);
		run(OP_BRANCH_AND_CLEAR_BIT, MD_SHORT_DIRECT, 3'h0, 8'h20, 8'h08, 1'b1, LEN_4, CYC_10);
		check({8'h00, mem_u.mem[16'hFE20]}, 16'h0000);
		run(OP_BRANCH_AND_CLEAR_BIT, MD_SPECIAL_REG, 3'h3, 8'h06, 8'h08, 1'b1, LEN_4, CYC_12);
		check({8'h00, mem_u.mem[16'hFF06]}, 16'h0000);
		reg_write(REG_PTR_HI, 8'h12);
		reg_write(REG_PTR_LO, 8'h34);
		run(OP_BRANCH_IF_BIT_SET, MD_POINTER_PAIR, 3'h1, 8'h00, 8'h04, 1'b1, LEN_3, CYC_11);
		run(OP_BRANCH_IF_BIT_CLEAR, MD_POINTER_PAIR, 3'h1, 8'h00, 8'h04, 1'b0, LEN_3, CYC_11);
		run(OP_BRANCH_AND_CLEAR_BIT, MD_POINTER_PAIR, 3'h1, 8'h00, 8'h04, 1'b1, LEN_3, CYC_12);
		check({8'h00, mem_u.mem[16'h1234]}, 16'h0000);
		reg_write(REG_B, 8'h02);
		run(OP_DECREMENT_BRANCH_NONZERO, MD_REG_B, 3'h0, 8'h00, 8'hFC, 1'b1, LEN_2, CYC_6);
		run(OP_DECREMENT_BRANCH_NONZERO, MD_REG_B, 3'h0, 8'h00, 8'hFC, 1'b0, LEN_2, CYC_6);
		reg_read(REG_B, 8'h00);
		run(OP_DECREMENT_BRANCH_NONZERO, MD_REG_C, 3'h0, 8'h00, 8'h06, 1'b1, LEN_2, CYC_6);
		reg_read(REG_C, 8'hFF);
		run(OP_DECREMENT_BRANCH_NONZERO, MD_SHORT_DIRECT, 3'h0, 8'h30, 8'h10, 1'b0, LEN_3, CYC_8);
		check({8'h00, mem_u.mem[16'hFE30]}, 16'h0000);
		run(OP_INTERRUPT_ENABLE_INSTRUCTION, MD_ACCUM, 3'h0, 8'h00, 8'h00, 1'b0, LEN_2, CYC_6);
		run(OP_REGISTER_BANK_SELECT, MD_ACCUM, 3'h0, 8'h03, 8'h00, 1'b0, LEN_2, CYC_4);
		reg_read(REG_STATUS, 8'hA8);
		run(OP_BRANCH_IF_BIT_SET, MD_STATUS_WORD, 3'h5, 8'h00, 8'h02, 1'b1, LEN_3, CYC_9);
		run(OP_BRANCH_IF_BIT_CLEAR, MD_STATUS_WORD, 3'h4, 8'h00, 8'h02, 1'b1, LEN_4, CYC_11);
		run(OP_BRANCH_AND_CLEAR_BIT, MD_STATUS_WORD, 3'h7, 8'h00, 8'h02, 1'b1, LEN_4, CYC_12);
		reg_read(REG_STATUS, 8'h28);
		run(OP_INTERRUPT_ENABLE_INSTRUCTION, MD_ACCUM, 3'h0, 8'h00, 8'h00, 1'b0, LEN_2, CYC_6);
		run(OP_INTERRUPT_DISABLE_INSTRUCTION, MD_ACCUM, 3'h0, 8'h00, 8'h00, 1'b0, LEN_2, CYC_6);
		check({15'h0000, master_interrupt_flag}, 16'h0000);
		run(OP_NO_OPERATION, MD_ACCUM, 3'h0, 8'h00, 8'h00, 1'b0, LEN_1, CYC_2);
		reg_write(REG_CLK_CTRL, 8'h01);
		slow = 1'b1;
		run(OP_NO_OPERATION, MD_ACCUM, 3'h0, 8'h00, 8'h00, 1'b0, LEN_1, CYC_2);
		check(16'(cyc >= 4 && cyc <= 6), 16'h0001);
		reg_write(REG_CLK_CTRL, 8'h00);
		slow = 1'b0;
		run(OP_HALT, MD_ACCUM, 3'h0, 8'h00, 8'h00, 1'b0, LEN_2, CYC_6);
		@(negedge mclk);
		check({14'h0000, halt_mode, instr_ready}, 16'h0002);
		wake_up();
		run(OP_STOP, MD_ACCUM, 3'h0, 8'h00, 8'h00, 1'b0, LEN_2, CYC_6);
		@(negedge mclk);
		check({14'h0000, stop_mode, instr_ready}, 16'h0002);
		wake_up();
		give_verdict();
	end
endmodule // bbc_exec_tb
